// [verilog/encoder_regmap_pkg.sv]
// encoder_regmap_pkg: register addresses, frame layout, codes, reset values and carrier types
// for the encoder register bank; assumes byte-wide request and response streams.
`default_nettype none
package encoder_regmap_pkg;
  // register addresses (16-bit register numbers)
  localparam logic [15:0] ADDR_POS_HI = 16'h0000; // shaft position, upper word
  localparam logic [15:0] ADDR_POS_LO = 16'h0001; // shaft position, lower word
  localparam logic [15:0] ADDR_WDOG = 16'h0051; // watchdog timeout in ms
  localparam logic [15:0] ADDR_CPT = 16'h0064; // counts per turn, upper word
  localparam logic [15:0] ADDR_TRES = 16'h0066; // total resolution
  localparam logic [15:0] ADDR_PRESET = 16'h0068; // preset value
  localparam logic [15:0] ADDR_SPEED = 16'h006A; // speed unit select
  localparam logic [15:0] ADDR_FLAGS = 16'h006C; // operating flags
  localparam logic [15:0] ADDR_TURN_RES = 16'h0070; // physical turn resolution
  localparam logic [15:0] ADDR_TURN_CNT = 16'h0072; // physical turn count
  localparam logic [15:0] ADDR_ALARM = 16'h0074; // alarm capability mask
  localparam logic [15:0] ADDR_WARN = 16'h0076; // warning capability mask
  localparam logic [15:0] ADDR_WR_LAST = 16'h006D; // last writable register
  localparam logic [15:0] ADDR_RD_LAST = 16'h0077; // last readable holding register
  // function and exception codes
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] MAX_RD_CNT = 16'h007D; // most registers in one read
  localparam logic [15:0] MAX_WR_CNT = 16'h007B; // most registers in one multiple write
  // byte positions within a frame
  localparam logic [8:0] IDX_TID_HI = 9'h000;
  localparam logic [8:0] IDX_TID_LO = 9'h001;
  localparam logic [8:0] IDX_PID_HI = 9'h002;
  localparam logic [8:0] IDX_PID_LO = 9'h003;
  localparam logic [8:0] IDX_LEN_HI = 9'h004;
  localparam logic [8:0] IDX_LEN_LO = 9'h005;
  localparam logic [8:0] IDX_UNIT = 9'h006;
  localparam logic [8:0] IDX_FC = 9'h007;
  localparam logic [8:0] IDX_ADDR_HI = 9'h008;
  localparam logic [8:0] IDX_ADDR_LO = 9'h009;
  localparam logic [8:0] IDX_CNT_HI = 9'h00A;
  localparam logic [8:0] IDX_CNT_LO = 9'h00B;
  localparam logic [8:0] IDX_BCNT = 9'h00C;
  localparam logic [8:0] IDX_DATA = 9'h00D;
  localparam logic [15:0] LEN_EXC = 16'h0003; // unit, function, code
  localparam logic [15:0] LEN_RD_BASE = 16'h0003; // unit, function, byte count
  localparam logic [15:0] LEN_WR = 16'h0006; // unit, function, address, count/value
  // reset values and field positions
  localparam logic [15:0] WDOG_RST = 16'h0000;
  localparam logic [31:0] PRESET_RST = 32'h0000_0000;
  localparam logic [31:0] SPEED_RST = 32'h0000_0000; // steps per second
  localparam logic [31:0] ALARM_CAPS = 32'h0000_7000;
  localparam logic [31:0] WARN_CAPS = 32'h0000_0000;
  localparam int FLAG_SCALE_BIT = 0;
  localparam int FLAG_DIR_BIT = 1;
  // one byte of a stream
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } byte_beat_t;
  // live configuration held by the bank
  typedef struct packed {
    logic [15:0] wdog_ms;
    logic wdog_en;
    logic [31:0] counts_per_turn;
    logic [31:0] total_resolution;
    logic [31:0] preset_value;
    logic [31:0] speed_unit_select;
    logic scaling_en;
    logic count_down;
  } encoder_cfg_t;
  typedef enum logic [1:0] {ST_RECV = 2'b00, ST_SEND = 2'b01} link_state_t;
endpackage : encoder_regmap_pkg
`default_nettype wire

// [verilog/encoder_modbus_register_map.sv]
// encoder_modbus_register_map: parses request frames byte by byte, serves reads and writes of the
// encoder registers, and streams back the response frame.
// assumes one request at a time, frames delimited by last, and synchronous inputs on sys_clk.
// Overview of operation
// - read reply: byte count, registers high byte first
// - position in input registers 0 and 1
// - preset value held at registers 104-105
// - watchdog timeout at 81, nonzero enables it
// - single write echoes address and stored value
// - multiple write reply gives start and count
// - 32-bit values upper word at lower address
// - flag bit0 scaling, bit1 direction, rest zero
// - alarm mask reads 00007000, warnings read zero
// - reset: watchdog, preset, speed, flags all zero
`timescale 1ns/1ns
`default_nettype none
module encoder_modbus_register_map #(
  parameter logic [31:0] CPT_DEFAULT = 32'h0000_1000, // counts per turn after reset
  parameter logic [31:0] TRES_DEFAULT = 32'h0100_0000, // total resolution after reset
  parameter logic [31:0] TURN_RES = 32'h0000_1000, // physical turn resolution
  parameter logic [31:0] TURN_CNT = 32'h0000_1000 // physical turn count
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire encoder_regmap_pkg::byte_beat_t rx_beat,
  output logic rx_ready,
  output encoder_regmap_pkg::byte_beat_t tx_beat,
  input wire logic tx_ready,
  input wire logic [31:0] shaft_position,
  output encoder_regmap_pkg::encoder_cfg_t cfg
);
  import encoder_regmap_pkg::*;

  // reads one 16-bit register of the holding or input map
  function automatic logic [15:0] rd_word(input encoder_cfg_t c, input logic [31:0] pos,
                                          input logic [15:0] a, input logic inmap);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (inmap) begin
      v = (a[15:1] == ADDR_POS_HI[15:1]) ? pos : 32'h0000_0000;
    end else begin
      case ({a[15:1], 1'b0})
        ADDR_CPT: v = c.counts_per_turn;
        ADDR_TRES: v = c.total_resolution;
        ADDR_PRESET: v = c.preset_value;
        ADDR_SPEED: v = c.speed_unit_select;
        ADDR_FLAGS: v = {30'h0000_0000, c.count_down, c.scaling_en};
        ADDR_TURN_RES: v = TURN_RES;
        ADDR_TURN_CNT: v = TURN_CNT;
        ADDR_ALARM: v = ALARM_CAPS;
        ADDR_WARN: v = WARN_CAPS;
        default: v = 32'h0000_0000;
      endcase
    end
    if (!inmap && a == ADDR_WDOG) begin
      rd_word = c.wdog_ms;
    end else begin
      rd_word = a[0] ? v[15:0] : v[31:16];
    end
  endfunction : rd_word

  // true when registers first..last all lie inside lo..hi
  function automatic logic in_span(input logic [15:0] first, input logic [16:0] last,
                                   input logic [15:0] lo, input logic [15:0] hi);
    in_span = (first >= lo) && (last <= {1'b0, hi});
  endfunction : in_span

  // exception code for a request header, or none
  function automatic logic [7:0] req_exc(input logic [7:0] fc, input logic [15:0] a,
                                         input logic [15:0] n);
    logic [16:0] last_a;
    logic one_wdog;
    last_a = {1'b0, a} + {1'b0, n} - 17'h00001;
    one_wdog = (a == ADDR_WDOG) && (n == 16'h0001);
    req_exc = EXC_NONE;
    case (fc)
      FC_RD_HOLD: begin
        if (n == 16'h0000 || n > MAX_RD_CNT) req_exc = EXC_VALUE;
        else if (!one_wdog && !in_span(a, last_a, ADDR_CPT, ADDR_RD_LAST)) req_exc = EXC_ADDR;
      end
      FC_RD_INPUT: begin
        if (n == 16'h0000 || n > MAX_RD_CNT) req_exc = EXC_VALUE;
        else if (!in_span(a, last_a, ADDR_POS_HI, ADDR_POS_LO)) req_exc = EXC_ADDR;
      end
      FC_WR_SINGLE: begin
        if (a != ADDR_WDOG && !in_span(a, {1'b0, a}, ADDR_CPT, ADDR_WR_LAST)) req_exc = EXC_ADDR;
      end
      FC_WR_MULTI: begin
        if (n == 16'h0000 || n > MAX_WR_CNT) req_exc = EXC_VALUE;
        else if (!one_wdog && !in_span(a, last_a, ADDR_CPT, ADDR_WR_LAST)) req_exc = EXC_ADDR;
      end
      default: req_exc = EXC_FUNC;
    endcase
  endfunction : req_exc

  logic rst_meta_ff; // first reset synchroniser stage
  logic rst_n_ff; // released reset used by the block
  link_state_t state_ff, nxt_state; // receiving or answering
  logic rx_ready_ff; // accepting request bytes
  byte_beat_t tx_ff; // response byte on the wire
  encoder_cfg_t cfg_ff, nxt_cfg; // live configuration
  logic [8:0] rx_idx_ff; // byte position in request
  logic [15:0] tid_ff; // transaction id to echo
  logic pid_bad_ff; // nonzero protocol id seen
  logic [7:0] unit_ff; // unit id to echo
  logic [7:0] fc_ff; // function code
  logic [15:0] addr_ff; // start address
  logic [15:0] cnt_ff; // register count or single value
  logic [7:0] exc_ff; // pending exception code
  logic [15:0] wr_ptr_ff; // register that the next data word hits
  logic [15:0] words_left_ff; // data words still expected
  logic [7:0] data_hi_ff; // upper byte of the data word in flight
  logic [15:0] pend_hi_ff; // upper half awaiting its lower half
  logic pend_vld_ff; // pend_hi_ff holds a value
  logic [31:0] pos_ff; // position frozen for the answer
  logic [8:0] tx_idx_ff; // next response byte

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // request side decode
  wire acc = rx_beat.valid && rx_ready_ff; // byte taken this cycle
  wire [15:0] cnt_now = {cnt_ff[15:8], rx_beat.data}; // count as it completes
  wire [7:0] exc_now = req_exc(fc_ff, addr_ff, cnt_now); // header check on count byte
  wire wr_single = acc && rx_idx_ff == IDX_CNT_LO && fc_ff == FC_WR_SINGLE && exc_now == EXC_NONE;
  wire wr_multi = acc && fc_ff == FC_WR_MULTI && exc_ff == EXC_NONE && rx_idx_ff >= IDX_DATA + 9'h001
                  && !rx_idx_ff[0] && words_left_ff != 16'h0000; // lower byte of a data word
  wire wr_go = (wr_single || wr_multi) && !pid_bad_ff;
  wire [15:0] wr_addr = wr_single ? addr_ff : wr_ptr_ff;
  wire [15:0] wr_data = {wr_single ? cnt_ff[15:8] : data_hi_ff, rx_beat.data};
  wire [15:0] wr_base = {wr_addr[15:1], 1'b0};
  wire [15:0] cur_hi = rd_word(cfg_ff, pos_ff, wr_base, 1'b0);
  wire [15:0] cur_lo = rd_word(cfg_ff, pos_ff, {wr_addr[15:1], 1'b1}, 1'b0);
  wire hold_hi = wr_multi && !wr_addr[0] && words_left_ff > 16'h0001; // upper half, lower follows
  wire [31:0] val32 = wr_addr[0] ? {pend_vld_ff ? pend_hi_ff : cur_hi, wr_data} : {wr_data, cur_lo};
  wire frame_ok = rx_idx_ff >= IDX_CNT_LO && !pid_bad_ff && !(rx_idx_ff == IDX_PID_LO && rx_beat.data != 8'h00);

  // configuration update from a committed write
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_go && !hold_hi) begin
      if (wr_addr == ADDR_WDOG) begin
        nxt_cfg.wdog_ms = wr_data;
        nxt_cfg.wdog_en = wr_data != 16'h0000;
      end else begin
        case (wr_base)
          ADDR_CPT: nxt_cfg.counts_per_turn = val32;
          ADDR_TRES: nxt_cfg.total_resolution = val32;
          ADDR_PRESET: nxt_cfg.preset_value = val32;
          ADDR_SPEED: nxt_cfg.speed_unit_select = val32;
          ADDR_FLAGS: begin
            nxt_cfg.scaling_en = val32[FLAG_SCALE_BIT];
            nxt_cfg.count_down = val32[FLAG_DIR_BIT];
          end
          default: nxt_cfg = cfg_ff;
        endcase
      end
    end
  end

  // response side decode
  wire is_read = fc_ff == FC_RD_HOLD || fc_ff == FC_RD_INPUT;
  wire [15:0] resp_len = (exc_ff != EXC_NONE) ? LEN_EXC
                       : is_read ? LEN_RD_BASE + {cnt_ff[14:0], 1'b0} : LEN_WR;
  wire [8:0] tx_total = resp_len[8:0] + IDX_UNIT;
  wire [8:0] rd_off = tx_idx_ff - IDX_ADDR_LO; // byte offset into read data
  wire [15:0] rd_val = rd_word(cfg_ff, pos_ff, addr_ff + {8'h00, rd_off[8:1]}, fc_ff == FC_RD_INPUT);
  wire [15:0] echo_val = rd_word(cfg_ff, pos_ff, addr_ff, 1'b0); // value as stored
  wire [15:0] wr_tail = (fc_ff == FC_WR_SINGLE) ? echo_val : cnt_ff;
  logic [7:0] tx_byte;

  // response byte at tx_idx_ff
  always_comb begin
    case (tx_idx_ff)
      IDX_TID_HI: tx_byte = tid_ff[15:8];
      IDX_TID_LO: tx_byte = tid_ff[7:0];
      IDX_PID_HI, IDX_PID_LO: tx_byte = 8'h00;
      IDX_LEN_HI: tx_byte = resp_len[15:8];
      IDX_LEN_LO: tx_byte = resp_len[7:0];
      IDX_UNIT: tx_byte = unit_ff;
      IDX_FC: tx_byte = (exc_ff != EXC_NONE) ? (fc_ff | EXC_FLAG) : fc_ff;
      IDX_ADDR_HI: begin
        if (exc_ff != EXC_NONE) tx_byte = exc_ff;
        else if (is_read) tx_byte = {cnt_ff[6:0], 1'b0};
        else tx_byte = addr_ff[15:8];
      end
      default: begin
        if (is_read) tx_byte = rd_off[0] ? rd_val[7:0] : rd_val[15:8];
        else if (tx_idx_ff == IDX_ADDR_LO) tx_byte = addr_ff[7:0];
        else if (tx_idx_ff == IDX_CNT_HI) tx_byte = wr_tail[15:8];
        else tx_byte = wr_tail[7:0];
      end
    endcase
  end

  wire tx_load = state_ff == ST_SEND && (!tx_ff.valid || tx_ready);

  // state flow: answer a complete frame, drop a malformed one
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RECV: if (acc && rx_beat.last && frame_ok) nxt_state = ST_SEND;
      ST_SEND: if (tx_load && tx_idx_ff == tx_total) nxt_state = ST_RECV;
      default: nxt_state = ST_RECV;
    endcase
  end

  // control, link and configuration registers
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_RECV;
      rx_ready_ff <= 1'b0;
      tx_ff <= '0;
      tx_idx_ff <= 9'h000;
      cfg_ff <= '{wdog_ms: WDOG_RST, wdog_en: 1'b0, counts_per_turn: CPT_DEFAULT,
                  total_resolution: TRES_DEFAULT, preset_value: PRESET_RST,
                  speed_unit_select: SPEED_RST, scaling_en: 1'b0, count_down: 1'b0};
      pos_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      rx_ready_ff <= nxt_state == ST_RECV;
      cfg_ff <= nxt_cfg;
      if (acc && rx_beat.last && frame_ok) begin
        pos_ff <= shaft_position; // frozen so both words agree
        tx_idx_ff <= 9'h000;
      end
      if (tx_load) begin
        if (tx_idx_ff == tx_total) begin
          tx_ff.valid <= 1'b0; // last byte taken
        end else begin
          tx_ff <= '{valid: 1'b1, last: tx_idx_ff == tx_total - 9'h001, data: tx_byte};
          tx_idx_ff <= tx_idx_ff + 9'h001;
        end
      end
    end
  end

  // request field capture
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rx_idx_ff <= 9'h000;
      tid_ff <= 16'h0000;
      pid_bad_ff <= 1'b0;
      unit_ff <= 8'h00;
      fc_ff <= 8'h00;
      addr_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
      exc_ff <= EXC_NONE;
      wr_ptr_ff <= 16'h0000;
      words_left_ff <= 16'h0000;
      data_hi_ff <= 8'h00;
      pend_hi_ff <= 16'h0000;
      pend_vld_ff <= 1'b0;
    end else if (acc) begin
      rx_idx_ff <= rx_beat.last ? 9'h000 : (rx_idx_ff == 9'h1FF ? rx_idx_ff : rx_idx_ff + 9'h001);
      case (rx_idx_ff)
        IDX_TID_HI: begin
          tid_ff[15:8] <= rx_beat.data;
          pid_bad_ff <= 1'b0;
          pend_vld_ff <= 1'b0;
        end
        IDX_TID_LO: tid_ff[7:0] <= rx_beat.data;
        IDX_PID_HI, IDX_PID_LO: if (rx_beat.data != 8'h00) pid_bad_ff <= 1'b1;
        IDX_UNIT: unit_ff <= rx_beat.data;
        IDX_FC: fc_ff <= rx_beat.data;
        IDX_ADDR_HI: addr_ff[15:8] <= rx_beat.data;
        IDX_ADDR_LO: addr_ff[7:0] <= rx_beat.data;
        IDX_CNT_HI: cnt_ff[15:8] <= rx_beat.data;
        IDX_CNT_LO: begin
          cnt_ff[7:0] <= rx_beat.data;
          exc_ff <= exc_now;
          wr_ptr_ff <= addr_ff;
          words_left_ff <= cnt_now;
        end
        IDX_BCNT: begin
          if (fc_ff == FC_WR_MULTI && exc_ff == EXC_NONE && rx_beat.data != {cnt_ff[6:0], 1'b0}) begin
            exc_ff <= EXC_VALUE;
          end
        end
        default: begin
          if (rx_idx_ff[0]) data_hi_ff <= rx_beat.data;
        end
      endcase
      if (wr_multi) begin
        wr_ptr_ff <= wr_ptr_ff + 16'h0001;
        words_left_ff <= words_left_ff - 16'h0001;
      end
      if (wr_go && hold_hi) begin
        pend_hi_ff <= wr_data;
        pend_vld_ff <= 1'b1;
      end else if (wr_go) begin
        pend_vld_ff <= 1'b0;
      end
    end
  end

  assign rx_ready = rx_ready_ff;
  assign tx_beat = tx_ff;
  assign cfg = cfg_ff;
endmodule : encoder_modbus_register_map
`default_nettype wire

// [bench/encoder_modbus_register_map_props.sv]
// encoder_modbus_register_map_props: port-level checks of the encoder register bank.
// assumes one clock sys_clk and the raw rst_b of the top module.
`timescale 1ns/1ns
`default_nettype none
module encoder_modbus_register_map_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire encoder_regmap_pkg::byte_beat_t rx_beat,
  input wire logic rx_ready,
  input wire encoder_regmap_pkg::byte_beat_t tx_beat,
  input wire logic tx_ready,
  input wire logic [31:0] shaft_position,
  input wire encoder_regmap_pkg::encoder_cfg_t cfg
);
  import encoder_regmap_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [8:0] tx_idx_ff; // byte position within the response
  logic [15:0] len_ff; // length field seen in the response
  wire logic tx_take = tx_beat.valid && tx_ready; // response byte handed over
  wire logic rx_take = rx_beat.valid && rx_ready; // request byte accepted
  // track the response byte index and catch its length field
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_idx_ff <= '0;
      len_ff <= '0;
    end else if (tx_take) begin
      tx_idx_ff <= tx_beat.last ? 9'h000 : tx_idx_ff + 9'h001;
      if (tx_idx_ff == IDX_LEN_HI) len_ff[15:8] <= tx_beat.data;
      if (tx_idx_ff == IDX_LEN_LO) len_ff[7:0] <= tx_beat.data;
    end
  end
  chk_tx_holds:
    assert property (tx_beat.valid && !tx_ready |=> $stable(tx_beat)) else $error("tx beat changed while stalled");
  chk_one_frame:
    assert property (tx_beat.valid |-> !rx_ready) else $error("request taken while answering");
  chk_proto_zero:
    assert property (tx_beat.valid && (tx_idx_ff == IDX_PID_HI || tx_idx_ff == IDX_PID_LO) |-> tx_beat.data == 8'h00)
    else $error("protocol id not zero");
  chk_len_match:
    assert property (tx_take && tx_beat.last |-> tx_idx_ff == len_ff + 16'h0005) else $error("length field mismatch");
  chk_wdog_enable:
    assert property (cfg.wdog_en == (cfg.wdog_ms != 16'h0000)) else $error("watchdog enable wrong");
  chk_reset_cfg:
    assert property (disable iff (1'b0) !rst_b ##1 !rst_b |-> cfg.preset_value == PRESET_RST && cfg.wdog_ms == WDOG_RST
      && cfg.speed_unit_select == SPEED_RST && !cfg.scaling_en && !cfg.count_down) else $error("cfg not at defaults");
  chk_frame_end:
    assert property (tx_take && tx_beat.last |=> !tx_beat.valid) else $error("tx valid after last byte");
  chk_cfg_steady:
    assert property (!rx_take |=> $stable(cfg)) else $error("cfg changed without a request byte");
  // main traffic shapes
  cover property (tx_take && tx_beat.last);
  cover property (tx_beat.valid && !tx_ready);
  cover property (tx_take && tx_idx_ff == IDX_FC && tx_beat.data[7]);
endmodule : encoder_modbus_register_map_props
bind encoder_modbus_register_map encoder_modbus_register_map_props i_encoder_modbus_register_map_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .rx_beat(rx_beat), .rx_ready(rx_ready), .tx_beat(tx_beat),
  .tx_ready(tx_ready), .shaft_position(shaft_position), .cfg(cfg));
`default_nettype wire

// [bench/modbus_client_model.sv]
// modbus_client_model: remote client sending request frames and collecting response bytes.
// assumes the bank's byte streams on sys_clk; drives at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module modbus_client_model (
  input wire logic sys_clk,
  output encoder_regmap_pkg::byte_beat_t rx_beat,
  input wire logic rx_ready,
  input wire encoder_regmap_pkg::byte_beat_t tx_beat,
  output logic tx_ready,
  input wire logic stall
);
  import encoder_regmap_pkg::*;
  logic [7:0] rxq[$]; // collected response bytes
  assign tx_ready = ~stall; // sink stalls when asked
  initial rx_beat = '0;
  // send a whole frame, each byte held until the bank takes it
  task automatic send(input logic [7:0] fr[$]);
    foreach (fr[i]) begin
      @(negedge sys_clk);
      rx_beat = '{valid: 1'b1, last: (i == fr.size() - 1), data: fr[i]};
      while (rx_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    rx_beat = '{valid: 1'b0, last: 1'b0, data: ~rx_beat.data}; // released line shows no stale byte
  endtask : send
  // collect bytes on the edges where they are handed over
  always @(posedge sys_clk) begin
    if (tx_beat.valid === 1'b1 && tx_ready) rxq.push_back(tx_beat.data);
  end
endmodule : modbus_client_model
`default_nettype wire

// [bench/encoder_modbus_register_map_test.sv]
// encoder_modbus_register_map_test: reads, writes and refusals compared with a register model.
// assumes the client model on the byte streams and a 100 MHz sys_clk.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module encoder_modbus_register_map_test;
  import encoder_regmap_pkg::*;
  localparam logic [31:0] CPT0 = 32'h0000_2000; // counts per turn after reset
  localparam logic [31:0] TRES0 = 32'h0200_0000; // total resolution after reset
  localparam logic [31:0] TRN_R = 32'h0000_0400; // turn resolution
  localparam logic [31:0] TRN_C = 32'h0000_0010; // turn count
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  byte_beat_t rx_beat;
  logic rx_ready;
  byte_beat_t tx_beat;
  logic tx_ready;
  logic [31:0] shaft_position = 32'h0000_2FF0;
  encoder_cfg_t cfg;
  logic stall = 1'b0; // sink stall, random in slow mode
  logic slow = 1'b0;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 23246;
  logic [15:0] m [0:127]; // holding register model
  logic [15:0] wd[$]; // words of a multiple write
  logic [7:0] req[$];
  logic [7:0] exp[$];
  encoder_modbus_register_map #(.CPT_DEFAULT(CPT0), .TRES_DEFAULT(TRES0), .TURN_RES(TRN_R), .TURN_CNT(TRN_C))
    i_encoder_modbus_register_map (.sys_clk(sys_clk), .rst_b(rst_b), .rx_beat(rx_beat), .rx_ready(rx_ready),
    .tx_beat(tx_beat), .tx_ready(tx_ready), .shaft_position(shaft_position), .cfg(cfg));
  modbus_client_model i_modbus_client_model (.sys_clk(sys_clk), .rx_beat(rx_beat), .rx_ready(rx_ready),
    .tx_beat(tx_beat), .tx_ready(tx_ready), .stall(stall));
  initial forever #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) stall <= slow & $random(seed);
  // stored value of a holding register write
  function automatic logic [15:0] store(input int a, input logic [15:0] v);
    return (a == 108) ? 16'h0000 : (a == 109) ? (v & 16'h0003) : v;
  endfunction : store
  // one request: build, predict, send, compare the response and the live configuration
  task automatic xfer(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] n, input logic [7:0] pid);
    logic [15:0] tid;
    logic [7:0] ec;
    logic [15:0] v;
    int k;
    tid = $random(seed);
    req = {tid[15:8], tid[7:0], 8'h00, pid, 8'h00, (fc == FC_WR_MULTI) ? 8'(7 + 2 * n) : 8'h06, 8'h11, fc,
      a[15:8], a[7:0], n[15:8], n[7:0]};
    if (fc == FC_WR_MULTI) req.push_back(8'(2 * n));
    foreach (wd[i]) req = {req, wd[i][15:8], wd[i][7:0]};
    if (fc != FC_WR_MULTI) req = req[0:11];
    ec = EXC_NONE;
    exp = {};
    if (pid == 8'h00) begin
      case (fc)
        FC_RD_HOLD, FC_RD_INPUT: begin
          if (n == 0 || n > MAX_RD_CNT) ec = EXC_VALUE;
          else if ((fc == FC_RD_INPUT) ? (a + n > 2) : !((a == ADDR_WDOG && n == 1) || (a >= 100 && a + n <= 120)))
            ec = EXC_ADDR;
          else begin
            exp = {8'(2 * n)};
            for (k = a; k < a + n; k++) begin
              v = (fc == FC_RD_INPUT) ? ((k == 0) ? shaft_position[31:16] : shaft_position[15:0]) : m[k];
              exp = {exp, v[15:8], v[7:0]};
            end
          end
        end
        FC_WR_SINGLE: begin
          if (!(a == ADDR_WDOG || (a >= 100 && a <= 109))) ec = EXC_ADDR;
          else begin
            m[a] = store(a, n);
            exp = {a[15:8], a[7:0], m[a][15:8], m[a][7:0]};
          end
        end
        FC_WR_MULTI: begin
          if (n == 0 || n > MAX_WR_CNT) ec = EXC_VALUE;
          else if (!((a == ADDR_WDOG && n == 1) || (a >= 100 && a + n <= 110))) ec = EXC_ADDR;
          else begin
            foreach (wd[i]) m[a + i] = store(a + i, wd[i]);
            exp = {a[15:8], a[7:0], n[15:8], n[7:0]};
          end
        end
        default: ec = EXC_FUNC;
      endcase
      if (ec != EXC_NONE) exp = {ec};
      exp = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(exp.size() + 2), 8'h11,
        (ec != EXC_NONE) ? (fc | EXC_FLAG) : fc, exp};
    end
    i_modbus_client_model.rxq = {};
    i_modbus_client_model.send(req);
    k = 0;
    while (i_modbus_client_model.rxq.size() < exp.size() && k < 300) begin
      @(negedge sys_clk);
      k++;
    end
    repeat ((exp.size() == 0) ? 30 : 3) @(negedge sys_clk);
    `CHK(i_modbus_client_model.rxq.size(), exp.size())
    foreach (exp[i]) if (i < i_modbus_client_model.rxq.size()) `CHK(i_modbus_client_model.rxq[i], exp[i])
    `CHK(cfg.wdog_ms, m[81])
    `CHK(cfg.wdog_en, (m[81] != 16'h0000))
    `CHK(cfg.counts_per_turn, {m[100], m[101]})
    `CHK(cfg.total_resolution, {m[102], m[103]})
    `CHK(cfg.preset_value, {m[104], m[105]})
    `CHK(cfg.speed_unit_select, {m[106], m[107]})
    `CHK({cfg.count_down, cfg.scaling_en}, m[109][1:0])
  endtask : xfer
  // print the counts and the verdict, then stop
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // hang guard
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
  // main sequence
  initial begin
    foreach (m[j]) m[j] = 16'h0000;
    {m[100], m[101], m[102], m[103]} = {CPT0, TRES0};
    {m[112], m[113], m[114], m[115]} = {TRN_R, TRN_C};
    {m[116], m[117], m[118], m[119]} = {ALARM_CAPS, WARN_CAPS};
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    xfer(FC_RD_HOLD, 16'd100, 16'd20, 8'h00);
    xfer(FC_RD_HOLD, ADDR_WDOG, 1, 0);
    xfer(FC_RD_INPUT, ADDR_POS_HI, 2, 0);
    xfer(FC_WR_SINGLE, ADDR_WDOG, 16'h000A, 0);
    xfer(FC_WR_SINGLE, ADDR_FLAGS + 16'h0001, 16'hFFFF, 0);
    wd = {16'h0000, 16'h0800, 16'h0080, 16'h0000};
    xfer(FC_WR_MULTI, ADDR_CPT, 4, 0);
    wd = {16'hFFFF, 16'hFFFF};
    xfer(FC_WR_MULTI, ADDR_FLAGS, 2, 0);
    wd = {16'h1234};
    xfer(FC_WR_MULTI, ADDR_WDOG, 1, 0);
    xfer(FC_WR_MULTI, ADDR_PRESET, 1, 0);
    wd = {};
    xfer(8'h2B, ADDR_CPT, 1, 0);
    xfer(FC_RD_HOLD, 16'h0010, 1, 0);
    xfer(FC_RD_HOLD, ADDR_CPT, 0, 0);
    xfer(FC_RD_HOLD, ADDR_CPT, 16'd126, 0);
    xfer(FC_RD_INPUT, ADDR_POS_LO, 2, 0);
    xfer(FC_WR_SINGLE, ADDR_ALARM, 16'h1111, 0);
    xfer(FC_RD_HOLD, ADDR_PRESET, 2, 8'h01);
    slow = 1'b1;
    repeat (8) begin
      shaft_position = $random(seed);
      wd = {16'($random(seed)), 16'($random(seed))};
      xfer(FC_WR_MULTI, ADDR_PRESET, 2, 0);
      wd = {};
      xfer(FC_WR_SINGLE, 16'(100 + {$random(seed)} % 10), 16'($random(seed)), 0);
      xfer(FC_RD_INPUT, ADDR_POS_HI, 2, 0);
      xfer(FC_RD_HOLD, ADDR_CPT, 10, 0);
    end
    wrap_up();
  end
endmodule : encoder_modbus_register_map_test
`default_nettype wire
